// file: inc/dsau_pkg.sv
`default_nettype none
package dsau_pkg;
   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam int          DSAU_AW          = 16;
   localparam int          DSAU_DW          = 16;
   localparam int          DSAU_MEM_BYTES   = 1024;
   localparam logic [15:0] DSAU_SFR_LAST    = 16'h07FF;
   localparam logic [15:0] DSAU_NEAR_LAST   = 16'h1FFF;
   localparam logic [15:0] DSAU_MEM_BASE    = 16'h0800;
   localparam int          DSAU_PSV_BIT     = 15;
   localparam int          DSAU_NEAR_AW     = 13;
   localparam logic [15:0] DSAU_STEP_BYTE   = 16'h0001;
   localparam logic [15:0] DSAU_STEP_WORD   = 16'h0002;
   localparam logic [15:0] DSAU_ZERO_WORD   = 16'h0000;
   localparam int          DSAU_NUM_WREG    = 16;

   // ----------------------------------------
   // Operations of the register-side unit
   // ----------------------------------------
   typedef enum logic [1:0] {
      DSAU_REG_NONE,
      DSAU_REG_LOAD,
      DSAU_REG_SIGN,
      DSAU_REG_ZERO
   } dsau_regop_t;

   // Address modes
   typedef enum logic [1:0] {
      DSAU_AM_NEAR,
      DSAU_AM_DIRECT,
      DSAU_AM_INDIRECT,
      DSAU_AM_POSTINC
   } dsau_amode_t;

   // One address generation request
   typedef struct packed {
      logic        valid;
      logic        byte_op;
      dsau_amode_t amode;
      logic [15:0] literal;
      logic [3:0]  ptr_sel;
   } dsau_agu_req_t;

   // Register-side request
   typedef struct packed {
      dsau_regop_t op;
      logic [3:0]  sel;
      logic        from_mem;
      logic [15:0] data;
   } dsau_reg_req_t;

   // Program space window request
   typedef struct packed {
      logic        rd;
      logic [14:0] addr;
      logic        byte_op;
   } dsau_psv_req_t;
endpackage : dsau_pkg
`default_nettype wire

// file: verilog/dsau_access_unit.sv
`default_nettype none
// Functional notes
// - Effective addresses are 16-bit byte addresses
// - Top bit clear is memory, set is window
// - 1 KB memory; unimplemented reads give zero
// - Low byte even address, high byte odd
// - Post-increment adds one byte, two word
// - Byte read selects lane, delivers low lane
// - Shared word decode, per-byte write strobes
// - Odd word access raises address error trap
// - Misaligned read completes, then trap
// - Misaligned write suppressed, then trap
// - Byte load changes working register low byte
// - Sign-extend byte to sixteen bits
// - Zero-extend clears register high byte
// - Lowest 2 KB reserved for function registers
// - Unused function register addresses read zero
// - Near region reached by 13-bit field
// - Full space via 16-bit direct or pointer
// - Independent read and write address units
module dsau_access_unit #(
   parameter int MEM_BYTES = dsau_pkg::DSAU_MEM_BYTES
) (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire dsau_pkg::dsau_agu_req_t rd_req,
   input  wire dsau_pkg::dsau_agu_req_t wr_req,
   input  wire logic [15:0]             wr_data,
   input  wire dsau_pkg::dsau_reg_req_t reg_req,
   input  wire logic [15:0]             sfr_rdata,
   input  wire logic                    sfr_hit,
   input  wire logic [15:0]             psv_rdata,
   output logic [15:0]                  rd_data,
   output logic                         rd_valid,
   output logic                         addr_trap,
   output logic [15:0]                  sfr_addr,
   output logic [1:0]                   sfr_wr_strobe,
   output logic [15:0]                  sfr_wdata,
   output dsau_pkg::dsau_psv_req_t      psv_req,
   output logic [15:0]                  wreg_view
);
   import dsau_pkg::*;

   localparam int WORDS = MEM_BYTES / 2;
   localparam int WA    = $clog2(WORDS);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [DSAU_NUM_WREG-1:0][15:0] wreg;
      logic [15:0]                    rd_data;
      logic                           rd_valid;
      logic                           trap;
      logic                           rd_hi;
      logic                           rd_byte;
      logic [1:0]                     rd_src;
      logic [15:0]                    sfr_word;
   } dsau_state_t;

   dsau_state_t       st;
   dsau_state_t       next_st;
   logic [15:0]       mem [WORDS];
   logic [15:0]       mem_q;
   logic [15:0]       rd_ea;
   logic [15:0]       wr_ea;
   logic              rd_mis;
   logic              wr_mis;
   logic              rd_mem;
   logic              wr_mem;
   logic [1:0]        lane_we;
   logic [15:0]       word_sel;
   logic [15:0]       ext_word;

   // ----------------------------------------
   // Address generation, one unit per direction
   // ----------------------------------------
   function automatic logic [15:0] dsau_ea(input dsau_agu_req_t r,
                                           input logic [15:0] ptr);
      logic [15:0] ea;
      ea = DSAU_ZERO_WORD;
      case (r.amode)
         DSAU_AM_NEAR:   ea = {3'h0, r.literal[DSAU_NEAR_AW-1:0]};
         DSAU_AM_DIRECT: ea = r.literal;
         default:        ea = ptr;
      endcase
      return ea;
   endfunction : dsau_ea

   // Separate units so read and write address apart
   assign rd_ea = dsau_ea(rd_req, st.wreg[rd_req.ptr_sel]);
   assign wr_ea = dsau_ea(wr_req, st.wreg[wr_req.ptr_sel]);

   // Word access on odd byte address is misaligned
   assign rd_mis = rd_req.valid && !rd_req.byte_op && rd_ea[0];
   assign wr_mis = wr_req.valid && !wr_req.byte_op && wr_ea[0];

   // Implemented memory sits above the function register area
   assign rd_mem = !rd_ea[DSAU_PSV_BIT] && rd_ea >= DSAU_MEM_BASE
                   && rd_ea < DSAU_MEM_BASE + 16'(MEM_BYTES);
   assign wr_mem = !wr_ea[DSAU_PSV_BIT] && wr_ea >= DSAU_MEM_BASE
                   && wr_ea < DSAU_MEM_BASE + 16'(MEM_BYTES);

   // Byte lane strobes; misaligned writes drop both
   always_comb begin
      lane_we = 2'b00;
      if (wr_req.valid && !wr_mis) begin
         if (wr_req.byte_op) begin
            lane_we = wr_ea[0] ? 2'b10 : 2'b01;
         end else begin
            lane_we = 2'b11;
         end
      end
   end

   // Byte write data is replicated so either lane carries it
   assign sfr_wdata = wr_req.byte_op ? {wr_data[7:0], wr_data[7:0]} : wr_data;
   assign sfr_addr  = wr_req.valid ? wr_ea : rd_ea;
   assign sfr_wr_strobe = (wr_ea <= DSAU_SFR_LAST) ? lane_we : 2'b00;

   // ----------------------------------------
   // Memory array, shared word decode
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (wr_mem && lane_we[0]) begin
         mem[WA'((wr_ea - DSAU_MEM_BASE) >> 1)][7:0] <= sfr_wdata[7:0];
      end
      if (wr_mem && lane_we[1]) begin
         mem[WA'((wr_ea - DSAU_MEM_BASE) >> 1)][15:8] <= sfr_wdata[15:8];
      end
      mem_q <= mem[WA'((rd_ea - DSAU_MEM_BASE) >> 1)];
   end

   // Program space window forwarding, one aggregate so the port has one driver
   assign psv_req = '{rd:      rd_req.valid && rd_ea[DSAU_PSV_BIT],
                      addr:    rd_ea[14:0],
                      byte_op: rd_req.byte_op};

   // ----------------------------------------
   // Read return path
   // ----------------------------------------
   always_comb begin
      case (st.rd_src)
         2'd1:    word_sel = mem_q;
         2'd2:    word_sel = st.sfr_word; // caught when the read was taken
         2'd3:    word_sel = psv_rdata;
         default: word_sel = DSAU_ZERO_WORD;
      endcase
   end

   // Byte read takes the addressed lane onto bits 7:0
   assign ext_word = st.rd_byte ?
                     {8'h00, (st.rd_hi ? word_sel[15:8] : word_sel[7:0])}
                     : word_sel;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st          = st;
      next_st.rd_valid = rd_req.valid;
      next_st.rd_hi    = rd_ea[0];
      next_st.rd_byte  = rd_req.byte_op;
      next_st.trap     = rd_mis || wr_mis;
      // Register answers follow the address of the moment, so they are caught
      // here; one cycle later the address belongs to the next request
      next_st.sfr_word = sfr_rdata;
      // Limitation: a concurrent write owns the register address, read sees zero
      if (rd_ea[DSAU_PSV_BIT]) begin
         next_st.rd_src = 2'd3;
      end else if (rd_mem) begin
         next_st.rd_src = 2'd1;
      end else if (rd_ea <= DSAU_SFR_LAST && sfr_hit && !wr_req.valid) begin
         next_st.rd_src = 2'd2;
      end else begin
         next_st.rd_src = 2'd0;
      end
      // Read data lands the cycle after the valid pulse, two cycles after the request
      if (st.rd_valid) begin
         next_st.rd_data = ext_word;
      end
      // Post-increment pointer updates, write unit last wins
      if (rd_req.valid && rd_req.amode == DSAU_AM_POSTINC) begin
         next_st.wreg[rd_req.ptr_sel] = st.wreg[rd_req.ptr_sel]
            + (rd_req.byte_op ? DSAU_STEP_BYTE : DSAU_STEP_WORD);
      end
      if (wr_req.valid && wr_req.amode == DSAU_AM_POSTINC) begin
         next_st.wreg[wr_req.ptr_sel] = st.wreg[wr_req.ptr_sel]
            + (wr_req.byte_op ? DSAU_STEP_BYTE : DSAU_STEP_WORD);
      end
      // Working register operations
      case (reg_req.op)
         DSAU_REG_LOAD: begin
            next_st.wreg[reg_req.sel][7:0] =
               reg_req.from_mem ? ext_word[7:0] : reg_req.data[7:0];
         end
         DSAU_REG_SIGN: begin
            next_st.wreg[reg_req.sel] = {{8{st.wreg[reg_req.sel][7]}},
                                         st.wreg[reg_req.sel][7:0]};
         end
         DSAU_REG_ZERO: begin
            next_st.wreg[reg_req.sel][15:8] = 8'h00;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign rd_data   = st.rd_data;
   assign rd_valid  = st.rd_valid;
   assign addr_trap = st.trap;
   assign wreg_view = st.wreg[reg_req.sel];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_odd_word_wr;
      wr_req.valid && !wr_req.byte_op && wr_ea[0];
   endsequence

   AST_WR_TRAP: assert property (@(posedge clk) disable iff (!reset_n)
      s_odd_word_wr |=> addr_trap) else $error("odd word write did not trap");
   AST_RD_TRAP: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && !rd_req.byte_op && rd_ea[0]) |=> addr_trap)
      else $error("odd word read did not trap");
   AST_NO_WR: assert property (@(posedge clk) disable iff (!reset_n)
      s_odd_word_wr |-> lane_we == 2'b00) else $error("misaligned write strobed");
   AST_NO_FALSE_TRAP: assert property (@(posedge clk) disable iff (!reset_n)
      !(rd_mis || wr_mis) |=> !addr_trap) else $error("spurious trap");
   AST_LANE: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_req.valid && wr_req.byte_op) |-> lane_we == (wr_ea[0] ? 2'b10 : 2'b01))
      else $error("wrong byte lane");
   AST_PSV: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && rd_ea[15]) |-> psv_req.rd) else $error("window not used");
   AST_BYTE_HI: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.byte_op) |=> ##1 rd_data[15:8] == 8'h00)
      else $error("byte read upper lane not zero");
   AST_INC: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.amode == DSAU_AM_POSTINC && !wr_req.valid
       && reg_req.op == DSAU_REG_NONE)
      |=> st.wreg[$past(rd_req.ptr_sel)] == $past(st.wreg[rd_req.ptr_sel])
          + ($past(rd_req.byte_op) ? 16'h0001 : 16'h0002))
      else $error("post increment step wrong");
   AST_ZE: assert property (@(posedge clk) disable iff (!reset_n)
      (reg_req.op == DSAU_REG_ZERO && !rd_req.valid && !wr_req.valid)
      |=> st.wreg[$past(reg_req.sel)][15:8] == 8'h00)
      else $error("zero extend left high byte");
   AST_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && !rd_ea[15] && !rd_mem && !(rd_ea <= DSAU_SFR_LAST && sfr_hit))
      |=> ##1 rd_data == 16'h0000) else $error("unimplemented read not zero");

   // ----------------------------------------
   // Answer timing, lanes and address units
   // ----------------------------------------
   // A read taken at an edge
   sequence s_rd_taken;
      rd_req.valid;
   endsequence

   // Byte write aimed at the function register region
   sequence s_sfr_byte_wr;
      wr_req.valid && wr_req.byte_op && wr_ea <= DSAU_SFR_LAST;
   endsequence

   // Register-only operations; a busy address unit could move the same pointer
   sequence s_byte_load;
      reg_req.op == DSAU_REG_LOAD && !rd_req.valid && !wr_req.valid;
   endsequence

   sequence s_sign_op;
      reg_req.op == DSAU_REG_SIGN && !rd_req.valid && !wr_req.valid;
   endsequence

   // Valid pulse follows every read and nothing else; a trap follows only a misaligned access
   AST_RD_VALID: assert property (@(posedge clk) disable iff (!reset_n)
      s_rd_taken |=> rd_valid) else $error("read not answered");
   AST_RD_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
      !rd_req.valid |=> !rd_valid) else $error("read answer without request");
   AST_TRAP_CAUSE: assert property (@(posedge clk) disable iff (!reset_n)
      addr_trap |-> $past(rd_mis || wr_mis)) else $error("trap without misaligned access");

   // Strobes stay in their region and on the addressed lane
   AST_SFR_LANE: assert property (@(posedge clk) disable iff (!reset_n)
      s_sfr_byte_wr |-> sfr_wr_strobe == (wr_ea[0] ? 2'b10 : 2'b01))
      else $error("register byte strobe on wrong lane");
   AST_SFR_REP: assert property (@(posedge clk) disable iff (!reset_n)
      s_sfr_byte_wr |-> sfr_wdata[15:8] == sfr_wdata[7:0])
      else $error("byte write data not on both lanes");
   AST_SFR_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_ea > DSAU_SFR_LAST) |-> sfr_wr_strobe == 2'b00)
      else $error("register strobe outside register region");
   AST_WORD_LANES: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_req.valid && !wr_req.byte_op && !wr_ea[0]) |-> lane_we == 2'b11)
      else $error("aligned word write missed a lane");

   // Address generation per mode
   AST_NEAR_EA: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.amode == DSAU_AM_NEAR) |-> rd_ea <= DSAU_NEAR_LAST)
      else $error("near address outside near region");
   AST_DIRECT_EA: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_req.valid && wr_req.amode == DSAU_AM_DIRECT) |-> wr_ea == wr_req.literal)
      else $error("direct write address altered");
   AST_INDIRECT_EA: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && rd_req.amode == DSAU_AM_INDIRECT)
      |-> rd_ea == st.wreg[rd_req.ptr_sel]) else $error("pointer address wrong");
   AST_APART: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && wr_req.valid && rd_req.amode == DSAU_AM_DIRECT
       && wr_req.amode == DSAU_AM_DIRECT)
      |-> rd_ea == rd_req.literal && wr_ea == wr_req.literal)
      else $error("address units not independent");

   // Window takes the upper half only, with the address unchanged
   AST_PSV_LOW: assert property (@(posedge clk) disable iff (!reset_n)
      (rd_req.valid && !rd_ea[DSAU_PSV_BIT]) |-> !psv_req.rd)
      else $error("lower half sent to window");
   AST_PSV_ADDR: assert property (@(posedge clk) disable iff (!reset_n)
      psv_req.rd |-> psv_req.addr == rd_ea[14:0]) else $error("window address wrong");

   // Working register byte operations
   AST_LOAD_HI: assert property (@(posedge clk) disable iff (!reset_n)
      s_byte_load |=> st.wreg[$past(reg_req.sel)][15:8]
                      == $past(st.wreg[reg_req.sel][15:8]))
      else $error("byte load changed high byte");
   AST_LOAD_LO: assert property (@(posedge clk) disable iff (!reset_n)
      (reg_req.op == DSAU_REG_LOAD && !reg_req.from_mem && !rd_req.valid && !wr_req.valid)
      |=> st.wreg[$past(reg_req.sel)][7:0] == $past(reg_req.data[7:0]))
      else $error("byte load low byte wrong");
   AST_SE: assert property (@(posedge clk) disable iff (!reset_n)
      s_sign_op |=> st.wreg[$past(reg_req.sel)][15:8]
                    == {8{$past(st.wreg[reg_req.sel][7])}})
      else $error("sign extension wrong");
   AST_ZE_LO: assert property (@(posedge clk) disable iff (!reset_n)
      (reg_req.op == DSAU_REG_ZERO && !rd_req.valid && !wr_req.valid)
      |=> st.wreg[$past(reg_req.sel)][7:0] == $past(st.wreg[reg_req.sel][7:0]))
      else $error("zero extend changed low byte");
endmodule : dsau_access_unit
`default_nettype wire

// file: sim/dsau_core_model.sv
`default_nettype none
// ----------------------------------------
// Core-side responder: one function register at 0x0080 and the window
// ----------------------------------------
module dsau_core_model (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic [15:0]             sfr_addr,
   input  wire logic [1:0]              sfr_wr_strobe,
   input  wire logic [15:0]             sfr_wdata,
   input  wire dsau_pkg::dsau_psv_req_t psv_req,
   output logic [15:0]                  sfr_rdata,
   output logic                         sfr_hit,
   output logic [15:0]                  psv_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import dsau_pkg::*;
   logic [15:0] reg_q;
   logic [15:0] junk;
   // Unused places drive churn, so a design that passes it through is seen
   assign sfr_hit   = (sfr_addr[15:1] == 15'h0040);
   assign sfr_rdata = sfr_hit ? reg_q : junk;
   // Lane writes and window data one cycle after the request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_q     <= 16'h0000;
         junk      <= 16'hA5C3;
         psv_rdata <= 16'h0000;
      end else begin
         junk <= junk + 16'h3B1D;
         if (sfr_hit && sfr_wr_strobe[0]) reg_q[7:0] <= sfr_wdata[7:0];
         if (sfr_hit && sfr_wr_strobe[1]) reg_q[15:8] <= sfr_wdata[15:8];
         psv_rdata <= psv_req.rd ? ({1'b1, psv_req.addr} ^ 16'h5A5A) : ~psv_rdata;
      end
   end
endmodule : dsau_core_model
`default_nettype wire

// file: sim/data_space_access_unit_test.sv
`default_nettype none
module data_space_access_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dsau_pkg::*;
   logic clk, reset_n, sfr_hit, rd_valid, addr_trap, pend;
   logic [15:0] wr_data, sfr_rdata, psv_rdata, rd_data, sfr_addr, sfr_wdata, wreg_view, rnd;
   logic [1:0] sfr_wr_strobe;
   dsau_agu_req_t rd_req, wr_req;
   dsau_reg_req_t reg_req;
   dsau_psv_req_t psv_req;
   logic [16:0] exp_q[$];
   logic [16:0] note;
   logic [15:0] ma[3] = '{16'h0800, 16'h0802, 16'h0BFE};
   logic [15:0] mv[3];
   int bad_count, check_count, traps, exp_traps;

   dsau_access_unit uut (.clk, .reset_n, .rd_req, .wr_req, .wr_data, .reg_req, .sfr_rdata,
      .sfr_hit, .psv_rdata, .rd_data, .rd_valid, .addr_trap, .sfr_addr, .sfr_wr_strobe,
      .sfr_wdata, .psv_req, .wreg_view);
   dsau_core_model core (.clk, .reset_n, .sfr_addr, .sfr_wr_strobe, .sfr_wdata, .psv_req,
      .sfr_rdata, .sfr_hit, .psv_rdata);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic dsau_agu_req_t agu(input logic b, input dsau_amode_t m,
         input logic [15:0] a, input logic [3:0] p);
      return '{valid: 1'b1, byte_op: b, amode: m, literal: a, ptr_sel: p};
   endfunction : agu
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      check_count++;
      if (got !== want) begin
         bad_count++;
         $display("BAD t=%0t got %h want %h", $time, got, want);
      end
   endtask : chk
   // One request cycle on all three units; defaults are idle
   task automatic cyc(input dsau_agu_req_t r, input dsau_agu_req_t w = '0,
         input logic [15:0] d = 16'h0000, input dsau_reg_req_t g = '0);
      @(posedge clk);
      rd_req  <= r;
      wr_req  <= w;
      wr_data <= d;
      reg_req <= g;
   endtask : cyc
   task automatic rd(input logic b, input dsau_amode_t m, input logic [15:0] a,
         input logic [15:0] e, input logic [3:0] p = 4'h0);
      exp_q.push_back({1'b1, e});
      cyc(agu(b, m, a, p));
   endtask : rd
   task automatic wr(input logic b, input logic [15:0] a, input logic [15:0] d);
      cyc('0, agu(b, DSAU_AM_DIRECT, a, 4'h0), d);
   endtask : wr
   task automatic rop(input dsau_regop_t o, input logic [3:0] s, input logic [15:0] d = 0);
      cyc('0, '0, 16'h0000, '{op: o, sel: s, from_mem: 1'b0, data: d});
   endtask : rop
   task automatic view(input logic [3:0] s, input logic [15:0] e);
      rop(DSAU_REG_NONE, s);
      @(negedge clk);
      chk(wreg_view, e);
   endtask : view
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Read data lands one edge after the valid pulse, so back-to-back is handled
   always @(negedge clk) begin
      if (pend) begin
         note = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1DEAD;
         if (note[16]) chk(rd_data, note[15:0]);
      end
      pend = (rd_valid === 1'b1);
      if (addr_trap === 1'b1) traps++;
   end
   // Watchdog: the sequence needs about 55 cycles
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      results();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rd_req = '0;
      wr_req = '0;
      reg_req = '0;
      wr_data = 16'h0000;
      reset_n = 1'b0;
      pend = 1'b0;
      rnd = 16'd29;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk(rd_data, 16'h0000);
      chk(wreg_view, 16'h0000);
      $display("reset test done");
      foreach (ma[i]) begin
         rnd = lfsr(rnd);
         mv[i] = rnd;
         wr(1'b0, ma[i], rnd);
      end
      foreach (ma[i]) rd(1'b0, DSAU_AM_DIRECT, ma[i], mv[i]);
      rd(1'b0, DSAU_AM_DIRECT, 16'h0C00, 16'h0000);
      rd(1'b0, DSAU_AM_DIRECT, 16'h7FFE, 16'h0000);
      rnd = lfsr(rnd);
      wr(1'b1, 16'h0801, rnd);
      mv[0][15:8] = rnd[7:0];
      rd(1'b1, DSAU_AM_DIRECT, 16'h0800, {8'h00, mv[0][7:0]});
      rd(1'b1, DSAU_AM_DIRECT, 16'h0801, {8'h00, rnd[7:0]});
      rd(1'b0, DSAU_AM_NEAR, 16'hE800, mv[0]);
      $display("memory test done");
      // Byte loads and sign extension only reach 0x00xx or 0xFFxx pointers, so
      // the pointer walks the window, whose data is a known function of address
      rop(DSAU_REG_LOAD, 4'h3, 16'h1280);
      rop(DSAU_REG_SIGN, 4'h3);
      rop(DSAU_REG_LOAD, 4'h5, 16'h12FF);
      rop(DSAU_REG_SIGN, 4'h5);
      rd(1'b0, DSAU_AM_POSTINC, 16'h0000, 16'hFF80 ^ 16'h5A5A, 4'h3);
      rd(1'b1, DSAU_AM_POSTINC, 16'h0000, 16'h00FF & (16'hFF82 ^ 16'h5A5A), 4'h3);
      rd(1'b1, DSAU_AM_INDIRECT, 16'h0000, (16'hFF83 ^ 16'h5A5A) >> 8, 4'h3);
      // Load from the read path takes the byte returned in this very cycle
      cyc('0, '0, 16'h0000, '{op: DSAU_REG_LOAD, sel: 4'h5, from_mem: 1'b1, data: 16'h0000});
      view(4'h3, 16'hFF83);
      view(4'h5, 16'hFF00 | ((16'hFF83 ^ 16'h5A5A) >> 8));
      rop(DSAU_REG_LOAD, 4'h6, 16'h3480);
      rop(DSAU_REG_SIGN, 4'h6);
      view(4'h6, 16'hFF80);
      rop(DSAU_REG_LOAD, 4'h6, 16'hAB7F);
      rop(DSAU_REG_SIGN, 4'h6);
      view(4'h6, 16'h007F);
      rop(DSAU_REG_ZERO, 4'h5);
      view(4'h5, 16'h00FF & ((16'hFF83 ^ 16'h5A5A) >> 8));
      $display("register test done");
      wr(1'b1, 16'h0081, 16'h00AB);
      @(negedge clk);
      chk(16'(sfr_wr_strobe), 16'h0002);
      wr(1'b1, 16'h0080, 16'h0055);
      @(negedge clk);
      chk(16'(sfr_wr_strobe), 16'h0001);
      rd(1'b0, DSAU_AM_DIRECT, 16'h0080, 16'hAB55);
      rd(1'b0, DSAU_AM_DIRECT, 16'h0100, 16'h0000);
      rd(1'b0, DSAU_AM_DIRECT, 16'h8ABC, 16'h8ABC ^ 16'h5A5A);
      @(negedge clk);
      chk({psv_req.rd, psv_req.addr}, 16'h8ABC);
      rnd = lfsr(rnd);
      exp_q.push_back({1'b1, mv[2]});
      cyc(agu(1'b0, DSAU_AM_DIRECT, 16'h0BFE, 4'h0), agu(1'b0, DSAU_AM_DIRECT, 16'h0802,
         4'h0), rnd);
      rd(1'b0, DSAU_AM_DIRECT, 16'h0802, rnd);
      $display("region test done");
      wr(1'b0, 16'h0081, 16'hFFFF);
      @(negedge clk);
      chk(16'(sfr_wr_strobe), 16'h0000);
      wr(1'b0, 16'h0803, 16'h1111);
      exp_q.push_back({1'b1, mv[0]});
      cyc(agu(1'b0, DSAU_AM_DIRECT, 16'h0801, 4'h0));
      rd(1'b0, DSAU_AM_DIRECT, 16'h0802, rnd);
      exp_traps = 3;
      repeat (4) cyc('0);
      chk(16'(traps), 16'(exp_traps));
      chk(16'(exp_q.size()), 16'h0000);
      $display("alignment test done");
      results();
   end
endmodule : data_space_access_unit_test
`default_nettype wire
